// >>> fpt_cmd_top.sv
// Function
// - After power-up the status register shows the last value written to its non-volatile copy.
// - A non-volatile status write is taken only after write enable 06h.
// - Code 50h enables a volatile status write that overrides the non-volatile value until power-off.
// - The status volatility parameter byte reads E8h, bit 3 marking the mixed scheme.
// - Soft reset is reset-enable 66h directly followed by reset 99h.
// - E9h leaves and B7h enters four-byte address mode, with no write enable needed.
// - Wide-address single-line reads 13h and 0Ch are accepted.
// - Wide-address dual reads 3Ch and BCh are accepted.
// - Wide-address quad reads 6Ch and ECh are accepted.
// - Wide-address page programs 12h and 34h are accepted.
// - Wide-address program 3Eh is rejected and its support flag reads 0.
// - Wide-address erase types 1 to 3 are accepted, type 4 is rejected and flagged 0.
// - Double-rate wide reads 0Eh, BEh and EEh are rejected and flagged 0.
// - Sector lock codes E0h, E1h and E2h are rejected and flagged 0.
// - Erase instruction bytes read 21h, 5Ch, DCh and FFh for types 1 to 4.
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
module fpt_cmd_top #(
	parameter int unsigned ADR_W = fpt_pkg::WB_ADR_W
) (
	// Clock and reset
	input  wire logic              ref_clk_i,
	input  wire logic              reset_n_i,
	// Wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [ADR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic                   wb_ack_o,
	output logic [31:0]            wb_dat_o,
	// Device state
	output logic                   wide_addr_mode_o
);

	fpt_link_if lnk ();

	fpt_param_rom u_rom (
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.lnk       (lnk.rom)
	);

	fpt_nv_status u_nv (
		.ref_clk_i (ref_clk_i),
		.reset_n_i (reset_n_i),
		.lnk       (lnk.nv)
	);

	fpt_pkg::fpt_bus_st_e   bus_st_r;
	fpt_pkg::fpt_bus_st_e   bus_st_nxt;
	fpt_pkg::fpt_op_class_e op_cls;
	logic [9:0]             idx;
	logic [7:0]             wbyte;
	logic [31:0]            rd_nxt;
	logic                   do_wr;
	logic                   cmd_go;
	logic                   cs_go;
	logic                   srw_go;
	logic                   act;
	logic                   soft_rst;
	logic                   wel_r;
	logic                   vwe_r;
	logic                   vol_act_r;
	logic [7:0]             vol_sr_r;
	logic                   addr4_r;
	logic                   armed_r;
	logic                   ign_r;
	logic [7:0]             last_op_r;
	logic [7:0]             sr_eff;

	assign idx   = wb_adr_i[11:2];
	assign wbyte = wb_dat_i[7:0];

	// Table index follows the held address; read data lands one edge later
	assign lnk.rom_idx = idx;

	// Bus sequencing: one fetch cycle covers the table's registered read
	always_comb begin
		bus_st_nxt = bus_st_r;
		case (bus_st_r)
			fpt_pkg::BS_IDLE: begin
				if (wb_cyc_i && wb_stb_i) begin
					bus_st_nxt = fpt_pkg::BS_FETCH;
				end
			end
			fpt_pkg::BS_FETCH: begin
				bus_st_nxt = fpt_pkg::BS_ACK;
			end
			fpt_pkg::BS_ACK: begin
				bus_st_nxt = fpt_pkg::BS_IDLE;
			end
			default: begin
				bus_st_nxt = fpt_pkg::BS_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bus_st_r <= fpt_pkg::BS_IDLE;
		end else begin
			bus_st_r <= bus_st_nxt;
		end
	end

	// Writes land on the edge that raises ack; only byte lane 0 is decoded
	assign do_wr  = (bus_st_r == fpt_pkg::BS_FETCH) && wb_cyc_i && wb_stb_i
		&& wb_we_i && wb_sel_i[0];
	assign cmd_go = do_wr && (idx == fpt_pkg::IDX_OPCODE);
	assign cs_go  = do_wr && (idx == fpt_pkg::IDX_CS_HIGH);
	assign srw_go = do_wr && (idx == fpt_pkg::IDX_SR_WRITE) && !ign_r;

	// Table indices have no write decode at all

	assign op_cls   = fpt_pkg::fpt_op_class(wbyte);
	assign act      = cmd_go && !ign_r;
	assign soft_rst = act && (op_cls == fpt_pkg::CL_RST) && armed_r;

	// Effective status: volatile copy wins once activated
	assign sr_eff = vol_act_r ? vol_sr_r : lnk.nv_q;

	// Non-volatile write needs write enable; volatile write needs 50h
	assign lnk.nv_we    = srw_go && wel_r;
	assign lnk.nv_wdata = wbyte;

	// Write enable latch
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wel_r <= 1'b0;
		end else if (soft_rst) begin
			wel_r <= 1'b0;
		end else if (act && (op_cls == fpt_pkg::CL_WREN)) begin
			wel_r <= 1'b1;
		end else if (act && (op_cls == fpt_pkg::CL_PROG || op_cls == fpt_pkg::CL_ERASE)) begin
			wel_r <= 1'b0;
		end else if (srw_go) begin
			wel_r <= 1'b0;
		end
	end

	// Volatile write enable latch
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			vwe_r <= 1'b0;
		end else if (soft_rst) begin
			vwe_r <= 1'b0;
		end else if (act && (op_cls == fpt_pkg::CL_VWREN)) begin
			vwe_r <= 1'b1;
		end else if (srw_go) begin
			vwe_r <= 1'b0;
		end
	end

	// Volatile copy: survives soft reset, cleared only by power reset
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			vol_act_r <= 1'b0;
			vol_sr_r  <= fpt_pkg::NV_SR_RST;
		end else if (srw_go && wel_r) begin
			vol_sr_r <= wbyte;
		end else if (srw_go && vwe_r) begin
			vol_act_r <= 1'b1;
			vol_sr_r  <= wbyte;
		end
	end

	// Address mode; no write enable is checked here
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			addr4_r <= 1'b0;
		end else if (soft_rst) begin
			addr4_r <= 1'b0;
		end else if (act && (op_cls == fpt_pkg::CL_ENTER_4B)) begin
			addr4_r <= 1'b1;
		end else if (act && (op_cls == fpt_pkg::CL_EXIT_4B)) begin
			addr4_r <= 1'b0;
		end
	end

	// Reset-enable must be the very instruction before the reset code
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			armed_r <= 1'b0;
		end else if (act) begin
			armed_r <= (op_cls == fpt_pkg::CL_RST_EN);
		end
	end

	// Ignore state: set by a rejected code, held until chip select ends
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ign_r <= 1'b0;
		end else if (cs_go) begin
			ign_r <= 1'b0;
		end else if (act && (op_cls == fpt_pkg::CL_NONE)) begin
			ign_r <= 1'b1;
		end
	end

	// Last accepted array instruction; program and erase need write enable
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			last_op_r <= fpt_pkg::LAST_RST;
		end else if (act && (op_cls == fpt_pkg::CL_READ)) begin
			last_op_r <= wbyte;
		end else if (act && wel_r && (op_cls == fpt_pkg::CL_PROG)) begin
			last_op_r <= wbyte;
		end else if (act && wel_r && (op_cls == fpt_pkg::CL_ERASE)) begin
			last_op_r <= wbyte;
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wide_addr_mode_o <= 1'b0;
		end else begin
			wide_addr_mode_o <= addr4_r;
		end
	end

	// Read decode; unmapped indices read zero
	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (lnk.rom_hit) begin
			rd_nxt[7:0] = lnk.rom_data;
		end else if (idx == fpt_pkg::IDX_STATE) begin
			rd_nxt[7:0]                = sr_eff;
			rd_nxt[fpt_pkg::ST_WEL]    = wel_r;
			rd_nxt[fpt_pkg::ST_VWE]    = vwe_r;
			rd_nxt[fpt_pkg::ST_VOL]    = vol_act_r;
			rd_nxt[fpt_pkg::ST_ADDR4]  = addr4_r;
			rd_nxt[fpt_pkg::ST_ARMED]  = armed_r;
			rd_nxt[fpt_pkg::ST_IGN]    = ign_r;
			rd_nxt[fpt_pkg::ST_LAST +: 8] = last_op_r;
		end else if (idx == fpt_pkg::IDX_NV_SR) begin
			rd_nxt[7:0] = lnk.nv_q;
		end else if (idx == fpt_pkg::IDX_OPCODE) begin
			rd_nxt[7:0] = last_op_r;
		end else begin
			rd_nxt = 32'h0000_0000;
		end
	end

	// Ack and read data: both registered; ack one cycle wide, read data held until the next transfer
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_st_r == fpt_pkg::BS_FETCH) begin
			wb_ack_o <= 1'b1;
			wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_nxt;
		end else begin
			wb_ack_o <= 1'b0;
		end
	end

endmodule // fpt_cmd_top
`default_nettype wire

// >>> fpt_cmd_top_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module fpt_cmd_top_assertions #(
	parameter int unsigned ADR_W = 12
) (
	input wire logic             ref_clk_i,
	input wire logic             reset_n_i,
	input wire logic             wb_cyc_i,
	input wire logic             wb_stb_i,
	input wire logic             wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0]       wb_sel_i,
	input wire logic [31:0]      wb_dat_i,
	input wire logic             wb_ack_o,
	input wire logic [31:0]      wb_dat_o,
	input wire logic             wide_addr_mode_o
);
	wire logic [9:0] idx = wb_adr_i[11:2];
	wire logic       rdack = wb_ack_o && !wb_we_i;
	wire logic       opwr = wb_ack_o && wb_we_i && wb_sel_i[0] && idx == fpt_pkg::IDX_OPCODE;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence req_s; $rose(wb_cyc_i && wb_stb_i); endsequence
	sequence ack_s; ##2 wb_ack_o ##1 !wb_ack_o; endsequence
	ack_timing_a: assert property (req_s |-> ack_s)
		else $error("ack not two cycles after request");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i, 2) && $past(wb_cyc_i))
		else $error("ack without request");
	sr_param_a: assert property (rdack && idx == 10'h06C |-> wb_dat_o == 32'h0000_00E8)
		else $error("status volatility byte wrong");
	rst_param_a: assert property (rdack && idx == 10'h06D |-> wb_dat_o == 32'h0000_0050)
		else $error("soft reset byte wrong");
	addr_param_a: assert property (rdack && idx == 10'h06E |-> wb_dat_o == 32'h0000_00C1 ##0 1)
		else $error("exit byte wrong");
	read_sup_a: assert property (rdack && idx == 10'h0C0 |-> wb_dat_o == 32'h0000_00FF)
		else $error("read support byte wrong");
	pe_sup_a: assert property (rdack && idx == 10'h0C1 |-> wb_dat_o == 32'h0000_000E)
		else $error("erase support byte wrong");
	lock_sup_a: assert property (rdack && idx == 10'h0C2 |-> wb_dat_o == 32'h0000_00F0)
		else $error("lock support byte wrong");
	erase_byte_a: assert property (rdack && idx == 10'h0C4 |-> wb_dat_o == 32'h0000_0021)
		else $error("erase type 1 byte wrong");
	unmapped_rd_a: assert property (rdack && idx > 10'h104 |-> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	mode_rise_a: assert property ($rose(wide_addr_mode_o) |-> $past(opwr && wb_dat_i[7:0] == 8'hB7))
		else $error("mode set without enter code");
	mode_fall_a: assert property ($fell(wide_addr_mode_o) |->
		$past(opwr && (wb_dat_i[7:0] == 8'hE9 || wb_dat_i[7:0] == 8'h99)))
		else $error("mode cleared without exit or reset");
endmodule // fpt_cmd_top_assertions
bind fpt_cmd_top fpt_cmd_top_assertions #(.ADR_W(ADR_W)) chk_u (.ref_clk_i, .reset_n_i,
	.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o,
	.wide_addr_mode_o);
`default_nettype wire

// >>> fpt_cmd_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module fpt_cmd_top_test;
	logic        ref_clk_i;
	logic        reset_n_i;
	logic        cyc, stb, we, ack, mode;
	logic [3:0]  sel;
	logic [11:0] adr;
	logic [31:0] wdat, rdat, q, lfsr;
	logic [7:0]  last, v;
	int          miscompares, cmp_count, cycles, k;
	logic [9:0]  tidx [12] = '{10'h06C, 10'h06D, 10'h06E, 10'h06F, 10'h0C0, 10'h0C1,
		10'h0C2, 10'h0C3, 10'h0C4, 10'h0C5, 10'h0C6, 10'h0C7};
	logic [7:0]  tval [12] = '{8'hE8, 8'h50, 8'hC1, 8'hA5, 8'hFF, 8'h0E, 8'hF0, 8'hFF,
		8'h21, 8'h5C, 8'hDC, 8'hFF};
	logic [7:0]  rdops [6] = '{8'h13, 8'h0C, 8'h3C, 8'hBC, 8'h6C, 8'hEC};
	logic [7:0]  pgops [5] = '{8'h12, 8'h34, 8'h21, 8'h5C, 8'hDC};
	logic [7:0]  bad [8] = '{8'h3E, 8'hFF, 8'h0E, 8'hBE, 8'hEE, 8'hE0, 8'hE1, 8'hE2};

	fpt_cmd_top dut_u (.ref_clk_i, .reset_n_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
		.wide_addr_mode_o(mode));
	fpt_host_model host_u (.ref_clk_i, .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
		.we_o(we), .sel_o(sel), .adr_o(adr), .dat_o(wdat));

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Expected state word: status, flag bits and last accepted array code
	function automatic logic [31:0] st_exp(input logic [7:0] sr, input logic [7:0] fl,
		input logic [7:0] lo);
		return {8'h00, lo, fl, sr};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic state_is(input logic [31:0] e);
		host_u.rd(fpt_pkg::IDX_STATE, q);
		chk("state", e, q);
		chk("mode pin", {31'h0, e[11]}, {31'h0, mode});
	endtask
	task automatic power_up;
		reset_n_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end
	// Whole run needs about six hundred cycles; the ceiling leaves wide margin
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			wrap_up();
		end
	end

	initial begin
		reset_n_i = 1'b0;
		lfsr = 32'h60b8ca2e;
		power_up();
		for (int i = 0; i < 12; i++) begin
			host_u.rd(tidx[i], q);
			chk("param", {24'h0, tval[i]}, q);
			lfsr = lfsr_next(lfsr);
			host_u.wr(tidx[i], lfsr);
			host_u.rd(tidx[i], q);
			chk("param after write", {24'h0, tval[i]}, q);
		end
		host_u.rd(10'h3FF, q);
		chk("unmapped", 32'h0, q);
		$display("test params done");
		host_u.wr(fpt_pkg::IDX_SR_WRITE, 32'h0000_005A);
		host_u.rd(fpt_pkg::IDX_NV_SR, q);
		chk("nv without enable", 32'h0, q);
		v = lfsr[7:0];
		host_u.sr_nv(v);
		host_u.rd(fpt_pkg::IDX_NV_SR, q);
		chk("nv", {24'h0, v}, q);
		host_u.sr_vol(~v);
		state_is(st_exp(~v, 8'h04, 8'h00));
		host_u.op(8'hB7);
		host_u.soft_rst();
		state_is(st_exp(~v, 8'h04, 8'h00));
		host_u.rd(fpt_pkg::IDX_NV_SR, q);
		chk("nv kept", {24'h0, v}, q);
		power_up();
		state_is(st_exp(v, 8'h00, 8'h00));
		$display("test status done");
		host_u.op(8'hB7);
		state_is(st_exp(v, 8'h08, 8'h00));
		host_u.op(8'hE9);
		state_is(st_exp(v, 8'h00, 8'h00));
		host_u.op(8'hB7);
		host_u.op(8'h99);
		state_is(st_exp(v, 8'h08, 8'h00));
		host_u.op(8'h66);
		host_u.op(8'h06);
		host_u.op(8'h99);
		state_is(st_exp(v, 8'h09, 8'h00));
		host_u.soft_rst();
		state_is(st_exp(v, 8'h00, 8'h00));
		host_u.wr_lane(fpt_pkg::IDX_OPCODE, 32'h0000_00B7, 4'hE);
		state_is(st_exp(v, 8'h00, 8'h00));
		$display("test mode done");
		for (int i = 0; i < 10; i++) begin
			lfsr = lfsr_next(lfsr);
			k = (i < 6) ? i : int'(lfsr % 6);
			host_u.op(rdops[k]);
			host_u.rd(fpt_pkg::IDX_OPCODE, q);
			chk("read code", {24'h0, rdops[k]}, q);
		end
		for (int i = 0; i < 5; i++) begin
			host_u.op(8'h06);
			host_u.op(pgops[i]);
			state_is(st_exp(v, 8'h00, pgops[i]));
		end
		last = 8'hDC;
		for (int i = 0; i < 8; i++) begin
			host_u.op(bad[i]);
			host_u.op(8'hB7);
			host_u.op(8'h13);
			state_is(st_exp(v, 8'h20, last));
			host_u.wr(fpt_pkg::IDX_CS_HIGH, lfsr);
			state_is(st_exp(v, 8'h00, last));
		end
		$display("test codes done");
		wrap_up();
	end
endmodule // fpt_cmd_top_test
`default_nettype wire

// >>> fpt_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module fpt_host_model (
	// Bus side
	input  wire logic        ref_clk_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] dat_i,
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic [3:0]       sel_o,
	output logic [11:0]      adr_o,
	output logic [31:0]      dat_o
);
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		sel_o = 4'h0;
		adr_o = 12'h000;
		dat_o = 32'h0000_0000;
	end
	// Request held until ack is seen at an edge; the gap before it keeps cyc low one cycle
	task automatic xfer(input logic w, input logic [9:0] i, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q);
		@(posedge ref_clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		sel_o <= s;
		adr_o <= {i, 2'b00};
		dat_o <= d;
		do @(posedge ref_clk_i); while (ack_i !== 1'b1);
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o <= 1'b0;
	endtask
	task automatic wr_lane(input logic [9:0] i, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] q;
		xfer(1'b1, i, d, s, q);
	endtask
	task automatic wr(input logic [9:0] i, input logic [31:0] d);
		wr_lane(i, d, 4'hF);
	endtask
	task automatic rd(input logic [9:0] i, output logic [31:0] q);
		xfer(1'b0, i, 32'h0000_0000, 4'hF, q);
	endtask
	task automatic op(input logic [7:0] c);
		wr(fpt_pkg::IDX_OPCODE, {24'h000000, c});
	endtask
	task automatic sr_nv(input logic [7:0] d);
		op(8'h06);
		wr(fpt_pkg::IDX_SR_WRITE, {24'h000000, d});
	endtask
	task automatic sr_vol(input logic [7:0] d);
		op(8'h50);
		wr(fpt_pkg::IDX_SR_WRITE, {24'h000000, d});
	endtask
	task automatic soft_rst;
		op(8'h66);
		op(8'h99);
	endtask
endmodule // fpt_host_model
`default_nettype wire

// >>> fpt_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface fpt_link_if;
	logic [9:0] rom_idx;
	logic [7:0] rom_data;
	logic       rom_hit;
	logic       nv_we;
	logic [7:0] nv_wdata;
	logic [7:0] nv_q;

	modport core (output rom_idx, output nv_we, output nv_wdata,
		input rom_data, input rom_hit, input nv_q);
	modport rom (input rom_idx, output rom_data, output rom_hit);
	modport nv (input nv_we, input nv_wdata, output nv_q);
endinterface
`default_nettype wire

// >>> fpt_nv_status.sv
`timescale 1ns/1ns
`default_nettype none
module fpt_nv_status (
	// Clock and reset
	input  wire logic  ref_clk_i,
	input  wire logic  reset_n_i,
	// Store port
	fpt_link_if.nv     lnk
);

	// Retained cell: power reset leaves it alone so the last write survives
	logic [7:0] cell_r = fpt_pkg::NV_SR_RST;

	// Writes are shut out while power is down
	always_ff @(posedge ref_clk_i) begin
		if (reset_n_i && lnk.nv_we) begin
			cell_r <= lnk.nv_wdata;
		end
	end

	assign lnk.nv_q = cell_r;

endmodule // fpt_nv_status
`default_nettype wire

// >>> fpt_param_rom.sv
`timescale 1ns/1ns
`default_nettype none
module fpt_param_rom (
	// Clock and reset
	input  wire logic  ref_clk_i,
	input  wire logic  reset_n_i,
	// Table port
	fpt_link_if.rom    lnk
);

	// Constant table, read data registered; no write path exists
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			lnk.rom_data <= 8'h00;
			lnk.rom_hit  <= 1'b0;
		end else begin
			lnk.rom_hit <= 1'b1;
			case (lnk.rom_idx)
				fpt_pkg::IDX_SR_VOL:   lnk.rom_data <= fpt_pkg::PV_SR_VOL;
				fpt_pkg::IDX_SOFT_RST: lnk.rom_data <= fpt_pkg::PV_SOFT_RST;
				fpt_pkg::IDX_EXIT_4B:  lnk.rom_data <= fpt_pkg::PV_EXIT_4B;
				fpt_pkg::IDX_ENTER_4B: lnk.rom_data <= fpt_pkg::PV_ENTER_4B;
				fpt_pkg::IDX_RD_SUP:   lnk.rom_data <= fpt_pkg::PV_RD_SUP;
				fpt_pkg::IDX_PE_SUP:   lnk.rom_data <= fpt_pkg::PV_PE_SUP;
				fpt_pkg::IDX_LOCK_SUP: lnk.rom_data <= fpt_pkg::PV_LOCK_SUP;
				fpt_pkg::IDX_LOCK_RSV: lnk.rom_data <= fpt_pkg::PV_LOCK_RSV;
				fpt_pkg::IDX_ERASE_T1: lnk.rom_data <= fpt_pkg::PV_ERASE_T1;
				fpt_pkg::IDX_ERASE_T2: lnk.rom_data <= fpt_pkg::PV_ERASE_T2;
				fpt_pkg::IDX_ERASE_T3: lnk.rom_data <= fpt_pkg::PV_ERASE_T3;
				fpt_pkg::IDX_ERASE_T4: lnk.rom_data <= fpt_pkg::PV_ERASE_T4;
				default: begin
					lnk.rom_data <= 8'h00;
					lnk.rom_hit  <= 1'b0;
				end
			endcase
		end
	end

endmodule // fpt_param_rom
`default_nettype wire

// >>> fpt_pkg.sv
`default_nettype none
package fpt_pkg;

	// Bus geometry
	localparam int unsigned WB_ADR_W = 12;
	localparam int unsigned IDX_W    = 10;

	// Register indices, byte address is four times the index
	localparam logic [9:0] IDX_SR_VOL   = 10'h06C;
	localparam logic [9:0] IDX_SOFT_RST = 10'h06D;
	localparam logic [9:0] IDX_EXIT_4B  = 10'h06E;
	localparam logic [9:0] IDX_ENTER_4B = 10'h06F;
	localparam logic [9:0] IDX_RD_SUP   = 10'h0C0;
	localparam logic [9:0] IDX_PE_SUP   = 10'h0C1;
	localparam logic [9:0] IDX_LOCK_SUP = 10'h0C2;
	localparam logic [9:0] IDX_LOCK_RSV = 10'h0C3;
	localparam logic [9:0] IDX_ERASE_T1 = 10'h0C4;
	localparam logic [9:0] IDX_ERASE_T2 = 10'h0C5;
	localparam logic [9:0] IDX_ERASE_T3 = 10'h0C6;
	localparam logic [9:0] IDX_ERASE_T4 = 10'h0C7;
	localparam logic [9:0] IDX_OPCODE   = 10'h100;
	localparam logic [9:0] IDX_CS_HIGH  = 10'h101;
	localparam logic [9:0] IDX_SR_WRITE = 10'h102;
	localparam logic [9:0] IDX_STATE    = 10'h103;
	localparam logic [9:0] IDX_NV_SR    = 10'h104;

	// Fixed parameter bytes
	localparam logic [7:0] PV_SR_VOL   = 8'hE8;
	localparam logic [7:0] PV_SOFT_RST = 8'h50;
	localparam logic [7:0] PV_EXIT_4B  = 8'hC1;
	localparam logic [7:0] PV_ENTER_4B = 8'hA5;
	localparam logic [7:0] PV_RD_SUP   = 8'hFF;
	localparam logic [7:0] PV_PE_SUP   = 8'h0E;
	localparam logic [7:0] PV_LOCK_SUP = 8'hF0;
	localparam logic [7:0] PV_LOCK_RSV = 8'hFF;
	localparam logic [7:0] PV_ERASE_T1 = 8'h21;
	localparam logic [7:0] PV_ERASE_T2 = 8'h5C;
	localparam logic [7:0] PV_ERASE_T3 = 8'hDC;
	localparam logic [7:0] PV_ERASE_T4 = 8'hFF;

	// Instruction codes
	localparam logic [7:0] OP_WREN      = 8'h06;
	localparam logic [7:0] OP_VSR_WREN  = 8'h50;
	localparam logic [7:0] OP_RST_EN    = 8'h66;
	localparam logic [7:0] OP_RST       = 8'h99;
	localparam logic [7:0] OP_EXIT_4B   = 8'hE9;
	localparam logic [7:0] OP_ENTER_4B  = 8'hB7;
	localparam logic [7:0] OP_RD4       = 8'h13;
	localparam logic [7:0] OP_FRD4      = 8'h0C;
	localparam logic [7:0] OP_FRD4_DO   = 8'h3C;
	localparam logic [7:0] OP_FRD4_DIO  = 8'hBC;
	localparam logic [7:0] OP_FRD4_QO   = 8'h6C;
	localparam logic [7:0] OP_FRD4_QIO  = 8'hEC;
	localparam logic [7:0] OP_PP4       = 8'h12;
	localparam logic [7:0] OP_PP4_QI    = 8'h34;
	localparam logic [7:0] OP_PP4_QIO   = 8'h3E;
	localparam logic [7:0] OP_DTR_RD4   = 8'h0E;
	localparam logic [7:0] OP_DTR_DIO4  = 8'hBE;
	localparam logic [7:0] OP_DTR_QIO4  = 8'hEE;
	localparam logic [7:0] OP_LOCK_VRD  = 8'hE0;
	localparam logic [7:0] OP_LOCK_VWR  = 8'hE1;
	localparam logic [7:0] OP_LOCK_NVRD = 8'hE2;

	// State register field positions
	localparam int unsigned ST_WEL   = 8;
	localparam int unsigned ST_VWE   = 9;
	localparam int unsigned ST_VOL   = 10;
	localparam int unsigned ST_ADDR4 = 11;
	localparam int unsigned ST_ARMED = 12;
	localparam int unsigned ST_IGN   = 13;
	localparam int unsigned ST_LAST  = 16;

	// Values after reset
	localparam logic [7:0] NV_SR_RST = 8'h00;
	localparam logic [7:0] LAST_RST  = 8'h00;

	typedef enum logic [3:0] {
		CL_NONE,
		CL_WREN,
		CL_VWREN,
		CL_RST_EN,
		CL_RST,
		CL_EXIT_4B,
		CL_ENTER_4B,
		CL_READ,
		CL_PROG,
		CL_ERASE
	} fpt_op_class_e;

	typedef enum logic [1:0] {
		BS_IDLE,
		BS_FETCH,
		BS_ACK
	} fpt_bus_st_e;

	// Support of each wide-address code follows its bit in the parameter table
	function automatic fpt_op_class_e fpt_op_class(input logic [7:0] op);
		fpt_op_class_e c;
		c = CL_NONE;
		case (op)
			OP_WREN:      c = CL_WREN;
			OP_VSR_WREN:  c = CL_VWREN;
			OP_RST_EN:    c = CL_RST_EN;
			OP_RST:       c = CL_RST;
			OP_EXIT_4B:   c = CL_EXIT_4B;
			OP_ENTER_4B:  c = CL_ENTER_4B;
			OP_RD4:       c = PV_RD_SUP[0] ? CL_READ : CL_NONE;
			OP_FRD4:      c = PV_RD_SUP[1] ? CL_READ : CL_NONE;
			OP_FRD4_DO:   c = PV_RD_SUP[2] ? CL_READ : CL_NONE;
			OP_FRD4_DIO:  c = PV_RD_SUP[3] ? CL_READ : CL_NONE;
			OP_FRD4_QO:   c = PV_RD_SUP[4] ? CL_READ : CL_NONE;
			OP_FRD4_QIO:  c = PV_RD_SUP[5] ? CL_READ : CL_NONE;
			OP_PP4:       c = PV_RD_SUP[6] ? CL_PROG : CL_NONE;
			OP_PP4_QI:    c = PV_RD_SUP[7] ? CL_PROG : CL_NONE;
			OP_PP4_QIO:   c = PV_PE_SUP[0] ? CL_PROG : CL_NONE;
			PV_ERASE_T1:  c = PV_PE_SUP[1] ? CL_ERASE : CL_NONE;
			PV_ERASE_T2:  c = PV_PE_SUP[2] ? CL_ERASE : CL_NONE;
			PV_ERASE_T3:  c = PV_PE_SUP[3] ? CL_ERASE : CL_NONE;
			PV_ERASE_T4:  c = PV_PE_SUP[4] ? CL_ERASE : CL_NONE;
			OP_DTR_RD4:   c = PV_PE_SUP[5] ? CL_READ : CL_NONE;
			OP_DTR_DIO4:  c = PV_PE_SUP[6] ? CL_READ : CL_NONE;
			OP_DTR_QIO4:  c = PV_PE_SUP[7] ? CL_READ : CL_NONE;
			OP_LOCK_VRD:  c = PV_LOCK_SUP[0] ? CL_READ : CL_NONE;
			OP_LOCK_VWR:  c = PV_LOCK_SUP[1] ? CL_READ : CL_NONE;
			OP_LOCK_NVRD: c = PV_LOCK_SUP[2] ? CL_READ : CL_NONE;
			default:      c = CL_NONE;
		endcase
		return c;
	endfunction

endpackage
`default_nettype wire
